// file: src/fsc_params.svh
// Constants of the flash status and configuration register group.
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// ============================================================
// Command codes
`define FSC_OP_WRITE_REGS 8'h01
`define FSC_OP_PROGRAM 8'h02
`define FSC_OP_CLR_LATCH 8'h04
`define FSC_OP_RD_STATUS 8'h05
`define FSC_OP_SET_LATCH 8'h06
`define FSC_OP_RD_SUSPEND 8'h07
`define FSC_OP_CLR_ERRORS 8'h30
`define FSC_OP_RD_CONFIG 8'h35
`define FSC_OP_ERASE 8'hd8

// ============================================================
// Reset values and timing
`define FSC_STATUS_RESET 8'h00
`define FSC_CONFIG_RESET 8'h00
`define FSC_SUSPEND_RESET 8'h00
`define FSC_WRITE_CYCLES 16

`endif

// file: src/fsc_pkg.sv
// Types of the flash status and configuration register group.
package fsc_pkg;

	// ============================================================
	// Register layouts, most significant field first.
	typedef struct packed {
		logic status_write_lock;
		logic prog_error;
		logic erase_error;
		logic protect_range_bit_high;
		logic protect_range_bit_mid;
		logic protect_range_bit_low;
		logic write_enable_latch;
		logic busy_flag;
	} fsc_status_t;

	typedef struct packed {
		logic latency_code_high;
		logic latency_code_low;
		logic protect_start_select;
		logic rsvd4;
		logic protect_volatility_select;
		logic rsvd2;
		logic quad_enable;
		logic freeze;
	} fsc_config_t;

	// ============================================================
	// Register write timer states.
	typedef enum logic [1:0] {
		FSC_IDLE = 2'b01,
		FSC_WRITING = 2'b10
	} fsc_state_t;

endpackage

// file: src/fsc_regs.sv
// Status, configuration and suspend registers behind a serial command port.
`timescale 1ns/10ps
`include "fsc_params.svh"

module fsc_regs #(
	parameter int WRITE_CYCLES = `FSC_WRITE_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic write_protect_n_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic engine_busy_i,
	input wire logic prog_fail_i,
	input wire logic erase_fail_i,
	input wire logic program_suspended_i,
	input wire logic erase_suspended_i,
	output logic prog_start_o,
	output logic erase_start_o,
	output logic [2:0] protect_range_o,
	output logic protect_start_select_o,
	output logic protect_volatility_select_o,
	output logic quad_enable_o,
	output logic freeze_o,
	output logic [1:0] latency_code_o
);

	// ============================================================
	// State
	logic [2:0] sclk_q, sclk_d, csn_q, csn_d;
	logic [1:0] mosi_q, mosi_d, wpn_q, wpn_d;
	fsc_pkg::fsc_state_t st_q, st_d;
	logic [15:0] wcnt_q, wcnt_d;
	logic [2:0] bits_q, bits_d;
	logic [1:0] nbytes_q, nbytes_d;
	logic [7:0] sh_q, sh_d, op_q, op_d, tx_q, tx_d;
	logic [7:0] sr_new_q, sr_new_d, cr_new_q, cr_new_d;
	logic miso_q, miso_d, oe_q, oe_d, pst_q, pst_d, est_q, est_d;
	fsc_pkg::fsc_status_t sr_q, sr_d, sr_view, sr_in;
	fsc_pkg::fsc_config_t cr_q, cr_d, cr_in;
	logic [1:0] susp_q, susp_d;
	logic rise, fall, desel, busy, locked, regs_wr_ok, clr_err;
	logic [7:0] byte_in;

	// ============================================================
	// Next state
	always_comb begin
		sclk_d = {sclk_q[1:0], sclk_i};
		csn_d = {csn_q[1:0], cs_n_i};
		mosi_d = {mosi_q[0], mosi_i};
		wpn_d = {wpn_q[0], write_protect_n_i};
		rise = sclk_q[1] & ~sclk_q[2];
		fall = ~sclk_q[1] & sclk_q[2];
		desel = csn_q[1] & ~csn_q[2];
		busy = (st_q == fsc_pkg::FSC_WRITING) | engine_busy_i;
		sr_view = sr_q;
		sr_view.busy_flag = busy;
		byte_in = {sh_q[6:0], mosi_q[1]};
		locked = sr_q.status_write_lock & ~wpn_q[1];
		regs_wr_ok = desel && op_q == `FSC_OP_WRITE_REGS && nbytes_q >= 2'd2 &&
			sr_q.write_enable_latch && !busy && !locked;
		clr_err = desel && op_q == `FSC_OP_CLR_ERRORS && nbytes_q == 2'd1;
		sr_in = fsc_pkg::fsc_status_t'(sr_new_q);
		cr_in = fsc_pkg::fsc_config_t'(cr_new_q);
		st_d = st_q;
		wcnt_d = wcnt_q;
		bits_d = bits_q;
		nbytes_d = nbytes_q;
		sh_d = sh_q;
		op_d = op_q;
		tx_d = tx_q;
		sr_new_d = sr_new_q;
		cr_new_d = cr_new_q;
		miso_d = miso_q;
		oe_d = oe_q;
		sr_d = sr_q;
		cr_d = cr_q;
		pst_d = 1'b0;
		est_d = 1'b0;
		susp_d = {erase_suspended_i, program_suspended_i};
		if (csn_q[1]) begin
			bits_d = 3'd0;
			nbytes_d = 2'd0;
			oe_d = 1'b0;
		end else if (rise) begin
			sh_d = byte_in;
			bits_d = bits_q + 3'd1;
			if (bits_q == 3'd7) begin
				if (nbytes_q != 2'd3) begin
					nbytes_d = nbytes_q + 2'd1;
				end
				if (nbytes_q == 2'd0) begin
					op_d = byte_in;
					oe_d = 1'b1;
					case (byte_in)
						`FSC_OP_RD_STATUS: tx_d = sr_view;
						`FSC_OP_RD_CONFIG: tx_d = cr_q;
						`FSC_OP_RD_SUSPEND: tx_d = {6'h00, susp_q};
						default: oe_d = 1'b0;
					endcase
				end else if (nbytes_q == 2'd1) begin
					sr_new_d = byte_in;
					cr_new_d = cr_q;
				end else if (nbytes_q == 2'd2) begin
					cr_new_d = byte_in;
				end
			end
		end else if (fall && oe_q) begin
			// Status is resampled each byte so busy polling sees fresh state.
			miso_d = tx_q[7];
			tx_d = {tx_q[6:0], tx_q[7]};
			if (bits_q == 3'd0 && op_q == `FSC_OP_RD_STATUS) begin
				miso_d = sr_view.status_write_lock;
				tx_d = {sr_view[6:0], sr_view[7]};
			end
		end
		if (desel && nbytes_q == 2'd1 && !busy) begin
			if (op_q == `FSC_OP_SET_LATCH) begin
				sr_d.write_enable_latch = 1'b1;
			end else if (op_q == `FSC_OP_CLR_LATCH) begin
				sr_d.write_enable_latch = 1'b0;
			end
		end
		if (desel && nbytes_q >= 2'd2 && sr_q.write_enable_latch && !busy) begin
			pst_d = op_q == `FSC_OP_PROGRAM;
			est_d = op_q == `FSC_OP_ERASE;
		end
		if (regs_wr_ok) begin
			st_d = fsc_pkg::FSC_WRITING;
			wcnt_d = 16'(WRITE_CYCLES - 1);
			sr_d.status_write_lock = sr_in.status_write_lock;
			if (!cr_q.freeze) begin
				sr_d.protect_range_bit_high = sr_in.protect_range_bit_high;
				sr_d.protect_range_bit_mid = sr_in.protect_range_bit_mid;
				sr_d.protect_range_bit_low = sr_in.protect_range_bit_low;
				// One-time bits can only be set, never cleared again.
				cr_d.protect_start_select = cr_q.protect_start_select |
					cr_in.protect_start_select;
			end
			cr_d.protect_volatility_select = cr_q.protect_volatility_select |
				cr_in.protect_volatility_select;
			cr_d.latency_code_high = cr_in.latency_code_high;
			cr_d.latency_code_low = cr_in.latency_code_low;
			cr_d.quad_enable = cr_in.quad_enable;
			cr_d.freeze = cr_q.freeze | cr_in.freeze;
		end else if (st_q == fsc_pkg::FSC_WRITING) begin
			wcnt_d = wcnt_q - 16'd1;
			if (wcnt_q == 16'd0) begin
				st_d = fsc_pkg::FSC_IDLE;
			end
		end
		// A failure reported in the clearing cycle still sets its flag.
		sr_d.prog_error = (sr_q.prog_error & ~clr_err) | prog_fail_i;
		sr_d.erase_error = (sr_q.erase_error & ~clr_err) | erase_fail_i;
		sr_d.busy_flag = 1'b0;
		cr_d.rsvd4 = 1'b0;
		cr_d.rsvd2 = 1'b0;
	end

	// ============================================================
	// Registers
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sclk_q <= 3'h0;
			csn_q <= 3'h7;
			mosi_q <= 2'h0;
			wpn_q <= 2'h3;
			st_q <= fsc_pkg::FSC_IDLE;
			wcnt_q <= 16'h0;
			bits_q <= 3'h0;
			nbytes_q <= 2'h0;
			sh_q <= 8'h00;
			op_q <= 8'h00;
			tx_q <= 8'h00;
			sr_new_q <= 8'h00;
			cr_new_q <= 8'h00;
			miso_q <= 1'b0;
			oe_q <= 1'b0;
			pst_q <= 1'b0;
			est_q <= 1'b0;
			sr_q <= `FSC_STATUS_RESET;
			cr_q <= `FSC_CONFIG_RESET;
			susp_q <= 2'h0;
		end else if (ce_i) begin
			sclk_q <= sclk_d;
			csn_q <= csn_d;
			mosi_q <= mosi_d;
			wpn_q <= wpn_d;
			st_q <= st_d;
			wcnt_q <= wcnt_d;
			bits_q <= bits_d;
			nbytes_q <= nbytes_d;
			sh_q <= sh_d;
			op_q <= op_d;
			tx_q <= tx_d;
			sr_new_q <= sr_new_d;
			cr_new_q <= cr_new_d;
			miso_q <= miso_d;
			oe_q <= oe_d;
			pst_q <= pst_d;
			est_q <= est_d;
			sr_q <= sr_d;
			cr_q <= cr_d;
			susp_q <= susp_d;
		end
	end

	assign miso_o = miso_q;
	assign miso_oe_o = oe_q;
	assign prog_start_o = pst_q;
	assign erase_start_o = est_q;
	assign protect_range_o = {sr_q.protect_range_bit_high,
		sr_q.protect_range_bit_mid, sr_q.protect_range_bit_low};
	assign protect_start_select_o = cr_q.protect_start_select;
	assign protect_volatility_select_o = cr_q.protect_volatility_select;
	assign quad_enable_o = cr_q.quad_enable;
	assign freeze_o = cr_q.freeze;
	assign latency_code_o = {cr_q.latency_code_high, cr_q.latency_code_low};

	// ============================================================
	// Checks
	chk_lock_blocks_write: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) ce_i && locked && desel &&
		op_q == `FSC_OP_WRITE_REGS |=> $stable(cr_q) &&
		$stable(protect_range_o) && $stable(sr_q.status_write_lock))
		else $error("register write taken while locked");
	chk_prog_flag_set: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) ce_i && prog_fail_i |=> sr_q.prog_error)
		else $error("program error flag not set");
	chk_erase_flag_set: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) ce_i && erase_fail_i |=> sr_q.erase_error)
		else $error("erase error flag not set");
	chk_start_needs_latch: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		prog_start_o || erase_start_o |-> $past(sr_q.write_enable_latch))
		else $error("operation started without write latch");
	chk_latch_only_cmds: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) $changed(sr_q.write_enable_latch) |->
		$past(desel) && ($past(op_q) == `FSC_OP_SET_LATCH ||
		$past(op_q) == `FSC_OP_CLR_LATCH))
		else $error("write latch changed by other command");
	chk_busy_after_write: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) ce_i && regs_wr_ok |=> sr_view.busy_flag[*8])
		else $error("busy not held after register write");
	chk_freeze_holds_bp: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) cr_q.freeze |=>
		$stable(protect_range_o) && $stable(protect_start_select_o))
		else $error("protection changed while frozen");
	// The loaded shift word is checked, since the serial line still shows
	// stale or suspend bits around the byte edges.
	chk_reserved_zero: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) !cr_q.rsvd4 && !cr_q.rsvd2 &&
		(!oe_q || $past(oe_q) || op_q != `FSC_OP_RD_SUSPEND ||
		tx_q[7:2] == 6'h00))
		else $error("reserved bit reads as one");
	chk_suspend_follow: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) ce_i |=>
		susp_q == $past({erase_suspended_i, program_suspended_i}))
		else $error("suspend status does not follow engine");
	cov_reg_write: cover property (@(posedge core_clk_i) regs_wr_ok);
	cov_locked_write: cover property (@(posedge core_clk_i)
		desel && op_q == `FSC_OP_WRITE_REGS && locked);
	cov_status_read: cover property (@(posedge core_clk_i)
		oe_q && op_q == `FSC_OP_RD_STATUS && busy);
	cov_program_start: cover property (@(posedge core_clk_i) prog_start_o);

endmodule

// file: verification/fsc_host.sv
// Serial host model that frames commands on the register port in mode 0.
`timescale 1ns/10ps

module fsc_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	// ============================================================
	// Frame transfer
	// The clock stands low between frames, and the data line flips so
	// that a stale bit cannot be taken for a valid one.
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	task automatic xfer(input int nb, input logic [23:0] tx,
		output logic [7:0] rx);
		int i;
		cs_n_o = 1'b0;
		rx = 8'h00;
		for (i = 0; i < nb * 8; i++) begin
			mosi_o = tx[23 - i];
			#62.5 sclk_o = 1'b1;
			rx = {rx[6:0], miso_i & miso_oe_i};
			#62.5 sclk_o = 1'b0;
		end
		#62.5 cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#100;
	endtask
endmodule

// file: verification/fsc_regs_tb.sv
// Self-checking bench of the flash status and configuration registers.
`timescale 1ns/10ps

module fsc_regs_tb;
	logic core_clk_i, sys_rst_i, sclk, cs_n, mosi, wp_n, miso, miso_oe;
	logic eng_busy, p_fail, e_fail, p_susp, e_susp, p_start, e_start;
	logic tb_sel, vsel, quad, frz;
	logic [2:0] prot;
	logic [1:0] lat;
	int err_total = 0;
	int n_tests = 0;
	int n_prog = 0;
	int n_erase = 0;
	int k;
	logic [7:0] exp_q[$];
	string name_q[$];
	logic [7:0] seen;
	event seen_ev;
	logic [16:0] lfsr_q = 17'h136d6;

	fsc_regs #(.WRITE_CYCLES(1000)) i_fsc_regs (.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .write_protect_n_i(wp_n), .miso_o(miso),
		.miso_oe_o(miso_oe), .engine_busy_i(eng_busy),
		.prog_fail_i(p_fail), .erase_fail_i(e_fail),
		.program_suspended_i(p_susp), .erase_suspended_i(e_susp),
		.prog_start_o(p_start), .erase_start_o(e_start),
		.protect_range_o(prot), .protect_start_select_o(tb_sel),
		.protect_volatility_select_o(vsel), .quad_enable_o(quad),
		.freeze_o(frz), .latency_code_o(lat));

	fsc_host i_fsc_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(miso_oe));

	// ============================================================
	// Helpers
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] got,
		input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cmd(input int nb, input logic [23:0] tx);
		logic [7:0] rx;
		i_fsc_host.xfer(nb, tx, rx);
	endtask

	task automatic exp_rd(input string nm, input logic [7:0] op,
		input logic [7:0] e);
		exp_q.push_back(e);
		name_q.push_back(nm);
		i_fsc_host.xfer(2, {op, 16'h0000}, seen);
		->seen_ev;
	endtask

	// Polling is bounded so that a stuck busy bit ends the run.
	task automatic wait_idle;
		logic [7:0] v;
		int n;
		for (n = 0; n < 20; n++) begin
			i_fsc_host.xfer(2, 24'h050000, v);
			if (v[0] === 1'b0)
				return;
		end
		err_total++;
		final_report;
	endtask

	// ============================================================
	// Clock, watchers and sequence
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	initial forever begin
		@seen_ev;
		check(name_q.pop_front(), seen, exp_q.pop_front());
	end

	always @(posedge core_clk_i) begin
		if (p_start === 1'b1)
			n_prog++;
		if (e_start === 1'b1)
			n_erase++;
	end

	initial begin
		sys_rst_i = 1'b1;
		{wp_n, eng_busy, p_fail, e_fail, p_susp, e_susp} = 6'h20;
		repeat (2) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge core_clk_i);
		exp_rd("status", 8'h05, 8'h00);
		exp_rd("config", 8'h35, 8'h00);
		exp_rd("suspend", 8'h07, 8'h00);
		cmd(3, 24'h019cff);
		wait_idle;
		exp_rd("no latch", 8'h05, 8'h00);
		cmd(1, 24'h060000);
		exp_rd("latch", 8'h05, 8'h02);
		cmd(3, 24'h018cfe);
		exp_rd("busy", 8'h05, 8'h8f);
		wait_idle;
		exp_rd("config", 8'h35, 8'hea);
		check("ports", {lat, tb_sel, quad, vsel, prot}, 8'hfb);
		@(negedge core_clk_i) wp_n = 1'b0;
		cmd(3, 24'h010000);
		wait_idle;
		exp_rd("locked", 8'h05, 8'h8e);
		@(negedge core_clk_i) wp_n = 1'b1;
		cmd(3, 24'h010c01);
		wait_idle;
		exp_rd("frozen cfg", 8'h35, 8'h29);
		cmd(3, 24'h011000);
		wait_idle;
		exp_rd("frozen bp", 8'h05, 8'h0e);
		check("freeze", {7'h00, frz}, 8'h01);
		cmd(1, 24'h040000);
		exp_rd("latch clr", 8'h05, 8'h0c);
		cmd(2, 24'h02aa00);
		cmd(2, 24'hd8aa00);
		cmd(1, 24'h060000);
		cmd(2, 24'h02aa00);
		cmd(2, 24'hd8aa00);
		check("starts", 8'(n_prog * 16 + n_erase), 8'h11);
		for (k = 0; k < 4; k++) begin
			lfsr_q = lfsr(lfsr_q);
			@(negedge core_clk_i) {e_susp, p_susp, eng_busy} = lfsr_q[2:0];
			exp_rd("suspend", 8'h07, {6'h00, lfsr_q[2:1]});
			exp_rd("busy eng", 8'h05, {7'h07, lfsr_q[0]});
		end
		@(negedge core_clk_i) eng_busy = 1'b0;
		@(negedge core_clk_i) p_fail = 1'b1;
		@(negedge core_clk_i) p_fail = 1'b0;
		exp_rd("prog err", 8'h05, 8'h4e);
		@(negedge core_clk_i) e_fail = 1'b1;
		@(negedge core_clk_i) e_fail = 1'b0;
		exp_rd("erase err", 8'h05, 8'h6e);
		cmd(1, 24'h300000);
		exp_rd("err clr", 8'h05, 8'h0e);
		#100;
		final_report;
	end
endmodule
